// file: hdl/rsc_map.svh
`ifndef RSC_MAP_SVH
`define RSC_MAP_SVH

// ****************************************
// Register map
// ****************************************
`define RSC_ADDR_W        8
`define RSC_OFS_CTRL      8'h00
`define RSC_OFS_MASK      8'h04
`define RSC_BIT_FLAG      0
`define RSC_BIT_IE        1
`define RSC_BIT_STAT      2
`define RSC_BIT_MASK      0
`define RSC_CTRL_RST      8'h00
`define RSC_MASK_RST      1'b1
`define RSC_REG_FULL      3'b011
`define RSC_REG_REDUCED   3'b100
`define RSC_REG_OFF       3'b000
`define RSC_ZERO8         8'h00

`endif

// file: hdl/rsc_pkg.sv
package rsc_pkg;
	typedef enum logic [2:0] {
		RSC_FULL     = 3'b001,
		RSC_REDUCED  = 3'b010,
		RSC_SHUTDOWN = 3'b100
	} rsc_mode_t;
endpackage

// file: hdl/rsc_top.sv
// The plain strobed port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "rsc_map.svh"

module rsc_top (
	input  wire logic                   CLK_SYS,     // 100 MHz bus clock
	input  wire logic                   RST,         // Async reset, active high
	input  wire logic [`RSC_ADDR_W-1:0] ADDR,        // Register address
	input  wire logic [7:0]             WDATA,       // Write data
	input  wire logic                   WR,          // Write strobe
	input  wire logic                   RD,          // Read strobe
	output logic      [7:0]             RDATA,       // Read data, cycle after RD
	input  wire logic                   REG_ENABLE,  // Regulator enable input pin
	input  wire logic                   STOP_MODE,   // Chip in stop mode
	input  wire logic                   CMP_QUIET_LOW,  // Quiet supply below assert level
	input  wire logic                   CMP_QUIET_HIGH, // Quiet supply above release level
	input  wire logic                   CMP_POR_OK,     // Core supply above power-up release
	input  wire logic                   CMP_DROP_LOW,   // Core supply below drop assert
	input  wire logic                   CMP_DROP_HIGH,  // Core supply above drop release
	output logic                        POR_OUT,     // Power-up reset request
	output logic                        DROP_RST,    // Supply-drop reset request
	output logic                        LOWV_IRQ,    // Low-voltage interrupt
	output logic                        AMP_EN,      // Error amplifier enable
	output logic                        BANDGAP_EN,  // Bandgap enable
	output logic                        CLAMP_EN,    // Clamp regulation select
	output logic                        OUT_EN,      // Regulator outputs driven
	output var rsc_pkg::rsc_mode_t      MODE         // Current operating mode
);
	import rsc_pkg::*;

	// ****************************************
	// Synchronisers
	// ****************************************
	logic [4:0] sync1_q;
	logic [4:0] sync2_q;
	wire  [4:0] async_in = {CMP_DROP_HIGH, CMP_DROP_LOW, CMP_POR_OK, CMP_QUIET_HIGH, CMP_QUIET_LOW};
	logic       en_s1_q;
	logic       en_s2_q;
	logic       stop_s1_q;
	logic       stop_s2_q;

	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			sync1_q   <= 5'h0;
			sync2_q   <= 5'h0;
			en_s1_q   <= 1'b0;
			en_s2_q   <= 1'b0;
			stop_s1_q <= 1'b0;
			stop_s2_q <= 1'b0;
		end else begin
			sync1_q   <= async_in;
			sync2_q   <= sync1_q;
			en_s1_q   <= REG_ENABLE;
			en_s2_q   <= en_s1_q;
			stop_s1_q <= STOP_MODE;
			stop_s2_q <= stop_s1_q;
		end
	end

	wire quiet_low  = sync2_q[0];
	wire quiet_high = sync2_q[1];
	wire por_ok     = sync2_q[2];
	wire drop_low   = sync2_q[3];
	wire drop_high  = sync2_q[4];

	// ****************************************
	// Mode selection
	// ****************************************
	rsc_mode_t mode_d;
	rsc_mode_t mode_q;

	assign mode_d = !en_s2_q ? RSC_SHUTDOWN : (stop_s2_q ? RSC_REDUCED : RSC_FULL);
	wire full_d = (mode_d == RSC_FULL);
	wire full_q = (mode_q == RSC_FULL);

	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			mode_q <= RSC_SHUTDOWN;
		end else begin
			mode_q <= mode_d;
		end
	end

	// ****************************************
	// Registers and detector
	// ****************************************
	logic stat_q;
	logic flag_q;
	logic ie_q;
	logic mask_q;
	logic drop_q;
	logic por_q;
	logic irq_q;
	logic [7:0] rdata_q;
	logic [2:0] reg_q;
	logic       outen_q;

	wire wr_ctrl = WR && (ADDR == `RSC_OFS_CTRL);
	wire wr_mask = WR && (ADDR == `RSC_OFS_MASK);
	wire clr_flag = wr_ctrl && WDATA[`RSC_BIT_FLAG];

	// Detector held at zero outside full mode; hysteresis keeps state between levels
	wire stat_d = !full_q ? 1'b0 : (quiet_low ? 1'b1 : (quiet_high ? 1'b0 : stat_q));
	wire stat_chg = (stat_d != stat_q);
	// Set beats clear so a change in the clearing cycle is not lost; mode entry never clears it
	wire flag_d = stat_chg ? 1'b1 : (clr_flag ? 1'b0 : flag_q);
	wire drop_d = !full_q ? 1'b0 : (drop_low ? 1'b1 : (drop_high ? 1'b0 : drop_q));
	wire ie_d   = wr_ctrl ? WDATA[`RSC_BIT_IE] : ie_q;
	wire mask_d = wr_mask ? WDATA[`RSC_BIT_MASK] : mask_q;
	wire irq_d  = flag_d && ie_d && mask_d;

	wire [7:0] ctrl_rd = {5'h0, stat_q, ie_q, flag_q};
	wire [7:0] rd_sel  = (ADDR == `RSC_OFS_CTRL) ? ctrl_rd :
	                     (ADDR == `RSC_OFS_MASK) ? {7'h0, mask_q} : `RSC_ZERO8;
	wire [7:0] rdata_d = RD ? rd_sel : `RSC_ZERO8;

	// Regulator controls: bit0 amp, bit1 bandgap, bit2 clamp
	wire [2:0] reg_d = (mode_d == RSC_FULL) ? `RSC_REG_FULL :
	                   ((mode_d == RSC_REDUCED) ? `RSC_REG_REDUCED : `RSC_REG_OFF);
	// Outputs stay driven in full and reduced modes, only shutdown floats them
	wire outen_d = (mode_d != RSC_SHUTDOWN);

	// ****************************************
	// Detector state
	// ****************************************
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			stat_q <= 1'b0;
			flag_q <= 1'b0;
		end else begin
			stat_q <= stat_d;
			flag_q <= flag_d;
		end
	end

	// ****************************************
	// Software controls
	// ****************************************
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			ie_q   <= 1'b0;
			mask_q <= `RSC_MASK_RST;
		end else begin
			ie_q   <= ie_d;
			mask_q <= mask_d;
		end
	end

	// ****************************************
	// Reset requests
	// ****************************************
	// Power-up request is high in reset so nothing starts before the supply is known good
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			drop_q <= 1'b0;
			por_q  <= 1'b1;
		end else begin
			drop_q <= drop_d;
			por_q  <= !por_ok;
		end
	end

	// ****************************************
	// Interrupt line
	// ****************************************
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= irq_d;
		end
	end

	// ****************************************
	// Read data
	// ****************************************
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			rdata_q <= `RSC_ZERO8;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	// ****************************************
	// Regulator controls
	// ****************************************
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			reg_q   <= `RSC_REG_OFF;
			outen_q <= 1'b0;
		end else begin
			reg_q   <= reg_d;
			outen_q <= outen_d;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign POR_OUT    = por_q;
	assign DROP_RST   = drop_q;
	assign LOWV_IRQ   = irq_q;
	assign RDATA      = rdata_q;
	assign AMP_EN     = reg_q[0];
	assign BANDGAP_EN = reg_q[1];
	assign CLAMP_EN   = reg_q[2];
	assign OUT_EN     = outen_q;
	assign MODE       = mode_q;

	// ****************************************
	// Checks
	// ****************************************
	chk_stat_set_low: assert property (@(posedge CLK_SYS) disable iff (RST)
		(full_q && quiet_low) |=> stat_q) else $error("status not set on low supply");
	chk_stat_clear_high: assert property (@(posedge CLK_SYS) disable iff (RST)
		(full_q && quiet_high && !quiet_low) |=> !stat_q) else $error("status not cleared");
	chk_flag_on_change: assert property (@(posedge CLK_SYS) disable iff (RST)
		(stat_q != $past(stat_q)) |-> flag_q) else $error("change did not set flag");
	chk_irq_follows_flag: assert property (@(posedge CLK_SYS) disable iff (RST)
		##1 (LOWV_IRQ == (flag_q && ie_q && mask_q))) else $error("irq mismatch");
	chk_flag_kept_mode: assert property (@(posedge CLK_SYS) disable iff (RST)
		(flag_q && !clr_flag && !full_d) |=> flag_q) else $error("flag lost on mode change");
	chk_detect_idle: assert property (@(posedge CLK_SYS) disable iff (RST)
		!full_q |=> !stat_q) else $error("detector active outside full mode");
	chk_por_track: assert property (@(posedge CLK_SYS) disable iff (RST)
		POR_OUT == !$past(por_ok)) else $error("power-up reset wrong");
	chk_drop_assert: assert property (@(posedge CLK_SYS) disable iff (RST)
		(full_q && drop_low) |=> DROP_RST) else $error("drop reset not asserted");
	chk_drop_idle: assert property (@(posedge CLK_SYS) disable iff (RST)
		!full_q |=> !DROP_RST) else $error("drop reset outside full mode");
	chk_reduced_clamp: assert property (@(posedge CLK_SYS) disable iff (RST)
		(mode_q == RSC_REDUCED) |-> (CLAMP_EN && !AMP_EN && !BANDGAP_EN)) else $error("reduced mode wrong");
	chk_flag_w1c: assert property (@(posedge CLK_SYS) disable iff (RST)
		(wr_ctrl && !WDATA[`RSC_BIT_FLAG] && flag_q) |=> flag_q) else $error("zero write cleared flag");
	chk_mode_select: assert property (@(posedge CLK_SYS) disable iff (RST)
		!en_s2_q |=> (mode_q == RSC_SHUTDOWN)) else $error("shutdown not selected");

	chk_por_release: assert property (@(posedge CLK_SYS) disable iff (RST)
		por_ok |=> !POR_OUT) else $error("power-up reset not released");

	chk_por_any_mode: assert property (@(posedge CLK_SYS) disable iff (RST)
		(!full_q && !por_ok) |=> POR_OUT) else $error("power-up reset off outside full mode");

	chk_drop_release: assert property (@(posedge CLK_SYS) disable iff (RST)
		(full_q && drop_high && !drop_low) |=> !DROP_RST) else $error("drop reset not released");

	chk_full_regulation: assert property (@(posedge CLK_SYS) disable iff (RST)
		(mode_q == RSC_FULL) |-> (AMP_EN && BANDGAP_EN && !CLAMP_EN)) else $error("full mode wrong");

	chk_irq_needs_flag: assert property (@(posedge CLK_SYS) disable iff (RST)
		LOWV_IRQ |-> (flag_q && ie_q)) else $error("irq without flag and enable");

	chk_flag_clear: assert property (@(posedge CLK_SYS) disable iff (RST)
		(clr_flag && !stat_chg) |=> !flag_q) else $error("flag not cleared by one");

	chk_stat_read_only: assert property (@(posedge CLK_SYS) disable iff (RST)
		(wr_ctrl && full_q && !quiet_low && !quiet_high) |=> (stat_q == $past(stat_q))) else $error("status written");

	chk_rdata_idle: assert property (@(posedge CLK_SYS) disable iff (RST)
		!RD |=> (RDATA == `RSC_ZERO8)) else $error("read data without read");

	chk_ie_write: assert property (@(posedge CLK_SYS) disable iff (RST)
		wr_ctrl |=> (ie_q == $past(WDATA[`RSC_BIT_IE]))) else $error("enable write lost");

	chk_shutdown_off: assert property (@(posedge CLK_SYS) disable iff (RST)
		(mode_q == RSC_SHUTDOWN) |-> !OUT_EN) else $error("outputs driven in shutdown");

	chk_stop_reduced: assert property (@(posedge CLK_SYS) disable iff (RST)
		(en_s2_q && stop_s2_q) |=> (mode_q == RSC_REDUCED)) else $error("stop did not select reduced");

	chk_run_full: assert property (@(posedge CLK_SYS) disable iff (RST)
		(en_s2_q && !stop_s2_q) |=> (mode_q == RSC_FULL)) else $error("run did not select full");

	chk_sync_depth: assert property (@(posedge CLK_SYS) disable iff (RST)
		quiet_low == $past(CMP_QUIET_LOW, 2)) else $error("comparator sync depth wrong");

endmodule // rsc_top

`default_nettype wire

// file: verif/rsc_partner.sv
`timescale 1ns/1ns
`default_nettype none
// ****************
// Reset generator and interrupt sink
// ****************
module rsc_partner (
	input  wire logic clk,     // Bus clock
	input  wire logic rst,     // Async reset
	input  wire logic por,     // Power-up reset request
	input  wire logic drop,    // Supply-drop reset request
	input  wire logic irq,     // Low-voltage interrupt
	output logic      chip_up, // Start-up sequence went on
	output logic      irq_seen // Sticky interrupt seen
);
	// Start-up proceeds only while no reset source requests reset
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			chip_up <= 1'b0;
			irq_seen <= 1'b0;
		end else begin
			chip_up <= !por && !drop;
			irq_seen <= irq_seen | irq;
		end
	end
endmodule // rsc_partner
`default_nettype wire

// file: verif/rsc_top_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "rsc_map.svh"
// ****************
// Bench
// ****************
module rsc_top_tb_top;
	import rsc_pkg::*;
	localparam logic [7:0] CT = `RSC_OFS_CTRL;
	localparam logic [7:0] MK = `RSC_OFS_MASK;
	logic CLK_SYS = 0, RST = 1, WR = 0, RD = 0, REG_ENABLE = 1, STOP_MODE = 0;
	logic CMP_QUIET_LOW = 0, CMP_QUIET_HIGH = 1, CMP_POR_OK = 0, CMP_DROP_LOW = 0, CMP_DROP_HIGH = 1;
	logic [7:0] ADDR = 8'h00, WDATA = 8'h00, RDATA;
	logic POR_OUT, DROP_RST, LOWV_IRQ, AMP_EN, BANDGAP_EN, CLAMP_EN, OUT_EN, chip_up, irq_seen;
	rsc_mode_t MODE;
	int errors = 0, cmp_count = 0, cyc = 0;
	always #5 CLK_SYS = ~CLK_SYS;
	rsc_top i_dut (.CLK_SYS, .RST, .ADDR, .WDATA, .WR, .RD, .RDATA, .REG_ENABLE, .STOP_MODE,
		.CMP_QUIET_LOW, .CMP_QUIET_HIGH, .CMP_POR_OK, .CMP_DROP_LOW, .CMP_DROP_HIGH, .POR_OUT,
		.DROP_RST, .LOWV_IRQ, .AMP_EN, .BANDGAP_EN, .CLAMP_EN, .OUT_EN, .MODE);
	rsc_partner i_far (.clk(CLK_SYS), .rst(RST), .por(POR_OUT), .drop(DROP_RST), .irq(LOWV_IRQ),
		.chip_up, .irq_seen);
	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		cmp_count++;
		if (s !== e) begin
			errors++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	// Pins pass two flops, so six edges cover every documented latency
	task automatic wt(input int n);
		repeat (n) @(posedge CLK_SYS);
		@(negedge CLK_SYS);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge CLK_SYS);
		ADDR <= a;
		WDATA <= d;
		WR <= 1'b1;
		@(posedge CLK_SYS);
		WR <= 1'b0;
		wt(3);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge CLK_SYS);
		ADDR <= a;
		RD <= 1'b1;
		@(posedge CLK_SYS);
		RD <= 1'b0;
		@(negedge CLK_SYS);
		chk(RDATA, e);
	endtask
	task automatic mode_case(input logic en, input logic st, input rsc_mode_t m, input logic [7:0] e);
		@(posedge CLK_SYS);
		REG_ENABLE <= en;
		STOP_MODE <= st;
		wt(6);
		chk(8'(MODE), 8'(m));
		chk({4'h0, AMP_EN, BANDGAP_EN, CLAMP_EN, OUT_EN}, e);
		chk(8'(POR_OUT), 8'h00);
	endtask
	task automatic report_and_stop();
		$display("compares=%0d mismatches=%0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// Whole run is about 120 cycles; ceiling leaves a wide margin
	always @(posedge CLK_SYS) begin
		cyc++;
		if (cyc == 3000) begin
			errors++;
			report_and_stop();
		end
	end
	initial begin
		repeat (2) @(posedge CLK_SYS);
		RST <= 1'b0;
		wt(6);
		chk(8'(POR_OUT), 8'h01);
		rd(CT, `RSC_CTRL_RST);
		rd(MK, 8'h01);
		rd(8'h10, `RSC_ZERO8);
		@(posedge CLK_SYS);
		CMP_POR_OK <= 1'b1;
		wt(6);
		chk({POR_OUT, chip_up}, 8'h01);
		$display("test 1 done");
		mode_case(1'b1, 1'b1, RSC_REDUCED, 8'h03);
		mode_case(1'b0, 1'b0, RSC_SHUTDOWN, 8'h00);
		mode_case(1'b1, 1'b0, RSC_FULL, 8'h0D);
		$display("test 2 done");
		@(posedge CLK_SYS);
		CMP_QUIET_HIGH <= 1'b0;
		CMP_QUIET_LOW <= 1'b1;
		wt(6);
		rd(CT, 8'h05);
		chk(8'(LOWV_IRQ), 8'h00);
		wr(CT, 8'h02);
		rd(CT, 8'h07);
		chk(8'(LOWV_IRQ), 8'h01);
		wr(MK, 8'h00);
		chk(8'(LOWV_IRQ), 8'h00);
		wr(MK, 8'h01);
		chk({LOWV_IRQ, irq_seen}, 8'h03);
		wr(CT, 8'h03);
		rd(CT, 8'h06);
		chk(8'(LOWV_IRQ), 8'h00);
		@(posedge CLK_SYS);
		CMP_QUIET_LOW <= 1'b0;
		wt(6);
		rd(CT, 8'h06);
		@(posedge CLK_SYS);
		CMP_QUIET_HIGH <= 1'b1;
		wt(6);
		rd(CT, 8'h03);
		$display("test 3 done");
		@(posedge CLK_SYS);
		STOP_MODE <= 1'b1;
		{CMP_QUIET_HIGH, CMP_QUIET_LOW, CMP_DROP_HIGH, CMP_DROP_LOW, CMP_POR_OK} <= 5'h0A;
		wt(6);
		rd(CT, 8'h03);
		chk({DROP_RST, POR_OUT, chip_up}, 8'h02);
		@(posedge CLK_SYS);
		STOP_MODE <= 1'b0;
		CMP_POR_OK <= 1'b1;
		wt(6);
		rd(CT, 8'h07);
		chk({DROP_RST, POR_OUT, chip_up}, 8'h04);
		@(posedge CLK_SYS);
		{CMP_DROP_HIGH, CMP_DROP_LOW} <= 2'h2;
		wt(6);
		chk({DROP_RST, POR_OUT, chip_up}, 8'h01);
		$display("test 4 done");
		report_and_stop();
	end
endmodule // rsc_top_tb_top
`default_nettype wire
